/* core/acs_chan.sv */
`timescale 1ns/1ps
module acs_chan (
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        enable,
    input  wire logic        startPulse,
    input  wire logic        extMode,
    input  wire logic        trackMode,
    input  wire logic [4:0]  divCount,
    input  wire logic [4:0]  convTicks,
    input  wire logic        captureEn,
    input  wire logic [15:0] coreData,
    output logic             busy,
    output logic             trackHold,
    output logic             convClk,
    output logic [15:0]      result
);
    acs_pkg::acs_state_e state_reg;
    acs_pkg::acs_state_e state_next;
    logic [4:0]  divCnt_reg;
    logic [4:0]  tickCnt_reg;
    logic        busy_reg;
    logic        trackHold_reg;
    logic        convClk_reg;
    logic [15:0] result_reg;
    logic        tick;
    logic        accept;
    logic        lastTick;

    assign tick     = (divCnt_reg == divCount);
    assign accept   = startPulse && enable && (state_reg == acs_pkg::ACS_IDLE);
    assign lastTick = tick && (state_reg == acs_pkg::ACS_CONV) && (tickCnt_reg == convTicks - 5'h01);

    // conversion clock: one tick every divCount+1 system clocks
    always_ff @(posedge sys_clk) begin
        if (!nrst || tick) begin
            divCnt_reg <= 5'h00;
        end else begin
            divCnt_reg <= divCnt_reg + 5'h01;
        end
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            acs_pkg::ACS_IDLE: begin
                if (accept) begin
                    state_next = (trackMode && !extMode) ? acs_pkg::ACS_TRACK : acs_pkg::ACS_CONV;
                end
            end
            acs_pkg::ACS_TRACK: begin
                if (tick && tickCnt_reg == acs_pkg::TRACK_TICKS - 5'h01) begin
                    state_next = acs_pkg::ACS_CONV;
                end
            end
            acs_pkg::ACS_CONV: begin
                if (lastTick) begin
                    state_next = acs_pkg::ACS_IDLE;
                end
            end
            default: state_next = acs_pkg::ACS_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state_reg <= acs_pkg::ACS_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // counts conversion clocks within a phase
    always_ff @(posedge sys_clk) begin
        if (!nrst || state_next != state_reg) begin
            tickCnt_reg <= 5'h00;
        end else if (tick) begin
            tickCnt_reg <= tickCnt_reg + 5'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= (state_next != acs_pkg::ACS_IDLE);
        end
    end

    // track while enabled and not in the conversion phase
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            trackHold_reg <= 1'b0;
        end else begin
            trackHold_reg <= enable && (state_next != acs_pkg::ACS_CONV);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            convClk_reg <= 1'b0;
        end else begin
            convClk_reg <= tick;
        end
    end

    // result is stored on the edge where busy falls, only when captureEn is set
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            result_reg <= 16'h0000;
        end else if (lastTick && captureEn) begin
            result_reg <= coreData;
        end
    end

    assign busy      = busy_reg;
    assign trackHold = trackHold_reg;
    assign convClk   = convClk_reg;
    assign result    = result_reg;

    property p_busyOnStart;
        @(posedge sys_clk) disable iff (!nrst) accept |=> busy_reg;
    endproperty
    a_busyOnStart: assert property (p_busyOnStart) else $error("busy not set after start");

    property p_trackFirst;
        @(posedge sys_clk) disable iff (!nrst)
            accept && trackMode && !extMode |=> state_reg == acs_pkg::ACS_TRACK && busy_reg;
    endproperty
    a_trackFirst: assert property (p_trackFirst) else $error("no tracking period before conversion");

    property p_extDirect;
        @(posedge sys_clk) disable iff (!nrst) accept && extMode |=> state_reg == acs_pkg::ACS_CONV;
    endproperty
    a_extDirect: assert property (p_extDirect) else $error("external start did not convert at once");

    property p_holdInConv;
        @(posedge sys_clk) disable iff (!nrst)
            state_reg == acs_pkg::ACS_CONV |-> !trackHold_reg ##0 busy_reg;
    endproperty
    a_holdInConv: assert property (p_holdInConv) else $error("tracking during conversion");

    property p_divWrap;
        @(posedge sys_clk) disable iff (!nrst) tick |=> divCnt_reg == 5'h00 ##0 convClk_reg;
    endproperty
    a_divWrap: assert property (p_divWrap) else $error("conversion clock divider wrong");

    property p_busyEnds;
        @(posedge sys_clk) disable iff (!nrst) lastTick |=> !busy_reg ##0 state_reg == acs_pkg::ACS_IDLE;
    endproperty
    a_busyEnds: assert property (p_busyEnds) else $error("busy did not clear at completion");

    property p_resultLoad;
        @(posedge sys_clk) disable iff (!nrst) lastTick && captureEn |=> result_reg == $past(coreData);
    endproperty
    a_resultLoad: assert property (p_resultLoad) else $error("result not stored at completion");

    c_trackConv: cover property (@(posedge sys_clk) disable iff (!nrst)
        state_reg == acs_pkg::ACS_TRACK ##1 state_reg == acs_pkg::ACS_CONV);
    c_finish: cover property (@(posedge sys_clk) disable iff (!nrst) lastTick);
endmodule : acs_chan

/* core/acs_pkg.sv */
package acs_pkg;

    // slow converter configuration register
    localparam logic [7:0] SLOW_CFG_ADDR      = 8'hbc;
    localparam logic [7:0] SLOW_CFG_RESET     = 8'hf8;
    localparam int         SLOW_DIV_LSB       = 3;
    localparam int         SLOW_DIV_MSB       = 7;
    localparam logic [4:0] SLOW_DIV_RESET     = SLOW_CFG_RESET[SLOW_DIV_MSB:SLOW_DIV_LSB];

    // conversion timing in conversion clocks
    localparam logic [4:0] TRACK_TICKS        = 5'h03;
    localparam logic [4:0] FAST_CONV_TICKS    = 5'h10;
    localparam logic [4:0] SLOW_CONV_TICKS    = 5'h0c;

    // channel indices
    localparam int         CH_FIRST           = 0;
    localparam int         CH_SECOND          = 1;
    localparam int         CH_SLOW            = 2;
    localparam int         NUM_CH             = 3;

    // start-of-conversion source codes
    typedef enum logic [2:0] {
        ACS_SRC_BUSY_WRITE  = 3'b000,
        ACS_SRC_TIMER3      = 3'b001,
        ACS_SRC_EXT_PIN     = 3'b010,
        ACS_SRC_TIMER2      = 3'b011,
        ACS_SRC_FIRST_BUSY  = 3'b100
    } acs_src_e;

    // sequencer states
    typedef enum logic [1:0] {
        ACS_IDLE  = 2'b00,
        ACS_TRACK = 2'b01,
        ACS_CONV  = 2'b10
    } acs_state_e;

endpackage : acs_pkg

/* core/acs_top.sv */
`timescale 1ns/1ps
module acs_top (
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic [7:0]  sfrAddr,
    input  wire logic        sfrWrEn,
    input  wire logic [7:0]  sfrWrData,
    output logic [7:0]       sfrRdData,
    input  wire logic        t2OvfLow,
    input  wire logic        t2OvfHigh,
    input  wire logic        t2Mode16,
    input  wire logic        t3OvfLow,
    input  wire logic        t3OvfHigh,
    input  wire logic        t3Mode16,
    input  wire logic        firstExtStartPin,
    input  wire logic        secondExtStartPin,
    input  wire logic        slowExtStartPin,
    input  wire logic        differentialSelect,
    input  wire logic        firstEnable,
    input  wire logic [1:0]  firstStartMode,
    input  wire logic        firstTrackMode,
    input  wire logic [3:0]  firstClkDiv,
    input  wire logic        firstBusyWrite,
    input  wire logic        firstDoneClear,
    input  wire logic        firstIrqEnable,
    input  wire logic        secondEnable,
    input  wire logic [2:0]  secondStartMode,
    input  wire logic        secondTrackMode,
    input  wire logic [3:0]  secondClkDiv,
    input  wire logic        secondBusyWrite,
    input  wire logic        secondDoneClear,
    input  wire logic        secondIrqEnable,
    input  wire logic        slowEnable,
    input  wire logic [1:0]  slowStartMode,
    input  wire logic        slowTrackMode,
    input  wire logic        slowBusyWrite,
    input  wire logic        slowDoneClear,
    input  wire logic        slowIrqEnable,
    input  wire logic [15:0] firstCoreData,
    input  wire logic [15:0] secondCoreData,
    input  wire logic [15:0] diffCoreData,
    input  wire logic [9:0]  slowCoreData,
    output logic             firstBusy,
    output logic             firstDoneFlag,
    output logic             firstIrq,
    output logic             firstTrackHold,
    output logic             firstConvClk,
    output logic [7:0]       firstResultHigh,
    output logic [7:0]       firstResultLow,
    output logic             secondBusy,
    output logic             secondDoneFlag,
    output logic             secondIrq,
    output logic             secondTrackHold,
    output logic             secondConvClk,
    output logic [7:0]       secondResultHigh,
    output logic [7:0]       secondResultLow,
    output logic             slowBusy,
    output logic             slowDoneFlag,
    output logic             slowIrq,
    output logic             slowTrackHold,
    output logic             slowConvClk,
    output logic [7:0]       slowResultHigh,
    output logic [7:0]       slowResultLow
);
    localparam int N = acs_pkg::NUM_CH;

    logic [4:0]  slowDiv_reg;
    logic [7:0]  rdData_reg;
    logic [N-1:0] pinMeta_reg;
    logic [N-1:0] pinSync_reg;
    logic [N-1:0] pinPrev_reg;
    logic [N-1:0] pinRise;
    logic        t2Ovf;
    logic        t3Ovf;
    logic [2:0]  mode       [N];
    logic [N-1:0] busyWrite;
    logic [N-1:0] doneClear;
    logic [N-1:0] irqEnable;
    logic [N-1:0] startPulse;
    logic [N-1:0] enable;
    logic [N-1:0] trackMode;
    logic [N-1:0] extMode;
    logic [N-1:0] captureEn;
    logic [4:0]  divCount   [N];
    logic [4:0]  convTicks  [N];
    logic [15:0] coreData   [N];
    logic [N-1:0] busy;
    logic [N-1:0] trackHold;
    logic [N-1:0] convClk;
    logic [15:0] result     [N];
    logic [N-1:0] busyPrev_reg;
    logic [N-1:0] done_reg;
    logic [N-1:0] irq_reg;

    // slow converter configuration register
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            slowDiv_reg <= acs_pkg::SLOW_DIV_RESET;
        end else if (sfrWrEn && sfrAddr == acs_pkg::SLOW_CFG_ADDR) begin
            slowDiv_reg <= sfrWrData[acs_pkg::SLOW_DIV_MSB:acs_pkg::SLOW_DIV_LSB];
        end
    end

    // read data; low bits and unmapped addresses read zero
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rdData_reg <= 8'h00;
        end else if (sfrAddr == acs_pkg::SLOW_CFG_ADDR) begin
            rdData_reg <= {slowDiv_reg, 3'h0};
        end else begin
            rdData_reg <= 8'h00;
        end
    end

    // start pin synchronisers and edge detect
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            pinMeta_reg <= '0;
            pinSync_reg <= '0;
            pinPrev_reg <= '0;
        end else begin
            pinMeta_reg <= {slowExtStartPin, secondExtStartPin, firstExtStartPin};
            pinSync_reg <= pinMeta_reg;
            pinPrev_reg <= pinSync_reg;
        end
    end
    assign pinRise = pinSync_reg & ~pinPrev_reg;

    assign t2Ovf = t2Mode16 ? t2OvfHigh : t2OvfLow;
    assign t3Ovf = t3Mode16 ? t3OvfHigh : t3OvfLow;

    // per-channel configuration; second follows first in differential mode
    always_comb begin
        mode[acs_pkg::CH_FIRST]       = {1'b0, firstStartMode};
        mode[acs_pkg::CH_SECOND]      = differentialSelect ? {1'b0, firstStartMode} : secondStartMode;
        mode[acs_pkg::CH_SLOW]        = {1'b0, slowStartMode};
        busyWrite                     = {slowBusyWrite, secondBusyWrite, firstBusyWrite};
        doneClear                     = {slowDoneClear, secondDoneClear, firstDoneClear};
        irqEnable                     = {slowIrqEnable, secondIrqEnable, firstIrqEnable};
        enable                        = {slowEnable, differentialSelect ? firstEnable : secondEnable, firstEnable};
        trackMode                     = {slowTrackMode, differentialSelect ? firstTrackMode : secondTrackMode,
                                         firstTrackMode};
        divCount[acs_pkg::CH_FIRST]   = {1'b0, firstClkDiv};
        divCount[acs_pkg::CH_SECOND]  = {1'b0, differentialSelect ? firstClkDiv : secondClkDiv};
        divCount[acs_pkg::CH_SLOW]    = slowDiv_reg;
        convTicks[acs_pkg::CH_FIRST]  = acs_pkg::FAST_CONV_TICKS;
        convTicks[acs_pkg::CH_SECOND] = acs_pkg::FAST_CONV_TICKS;
        convTicks[acs_pkg::CH_SLOW]   = acs_pkg::SLOW_CONV_TICKS;
        coreData[acs_pkg::CH_FIRST]   = differentialSelect ? diffCoreData : firstCoreData;
        coreData[acs_pkg::CH_SECOND]  = secondCoreData;
        coreData[acs_pkg::CH_SLOW]    = {6'h00, slowCoreData};
        captureEn                     = {1'b1, !differentialSelect, 1'b1};
    end

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_ch
            logic busyTrig;
            logic pinTrig;
            // in differential mode the second converter starts with the first
            assign busyTrig = (i == acs_pkg::CH_SECOND && differentialSelect) ? firstBusyWrite : busyWrite[i];
            assign pinTrig  = (i == acs_pkg::CH_SECOND && differentialSelect) ? pinRise[0] : pinRise[i];

            // trigger select, codes in listed order from zero
            always_comb begin
                case (mode[i])
                    acs_pkg::ACS_SRC_BUSY_WRITE: startPulse[i] = busyTrig;
                    acs_pkg::ACS_SRC_TIMER3:     startPulse[i] = t3Ovf;
                    acs_pkg::ACS_SRC_EXT_PIN:    startPulse[i] = pinTrig;
                    acs_pkg::ACS_SRC_TIMER2:     startPulse[i] = t2Ovf;
                    acs_pkg::ACS_SRC_FIRST_BUSY: startPulse[i] = (i == acs_pkg::CH_SECOND) && firstBusyWrite;
                    default:                     startPulse[i] = 1'b0;
                endcase
                extMode[i] = (mode[i] == acs_pkg::ACS_SRC_EXT_PIN);
            end

            acs_chan u_chan (
                .sys_clk    (sys_clk),
                .nrst       (nrst),
                .enable     (enable[i]),
                .startPulse (startPulse[i]),
                .extMode    (extMode[i]),
                .trackMode  (trackMode[i]),
                .divCount   (divCount[i]),
                .convTicks  (convTicks[i]),
                .captureEn  (captureEn[i]),
                .coreData   (coreData[i]),
                .busy       (busy[i]),
                .trackHold  (trackHold[i]),
                .convClk    (convClk[i]),
                .result     (result[i])
            );

            // completion flag: busy fall sets it, set wins over clear
            always_ff @(posedge sys_clk) begin
                if (!nrst) begin
                    busyPrev_reg[i] <= 1'b0;
                    done_reg[i]     <= 1'b0;
                end else begin
                    busyPrev_reg[i] <= busy[i];
                    if (busyPrev_reg[i] && !busy[i]) begin
                        done_reg[i] <= 1'b1;
                    end else if (doneClear[i]) begin
                        done_reg[i] <= 1'b0;
                    end
                end
            end

            always_ff @(posedge sys_clk) begin
                if (!nrst) begin
                    irq_reg[i] <= 1'b0;
                end else begin
                    irq_reg[i] <= done_reg[i] && irqEnable[i];
                end
            end

            property p_doneOnFall;
                @(posedge sys_clk) disable iff (!nrst) $fell(busy[i]) |=> done_reg[i];
            endproperty
            a_doneOnFall: assert property (p_doneOnFall) else $error("flag not set by busy fall");

            property p_doneSticky;
                @(posedge sys_clk) disable iff (!nrst) done_reg[i] && !doneClear[i] |=> done_reg[i];
            endproperty
            a_doneSticky: assert property (p_doneSticky) else $error("completion flag lost");

            property p_irqRaise;
                @(posedge sys_clk) disable iff (!nrst) done_reg[i] && irqEnable[i] |=> irq_reg[i];
            endproperty
            a_irqRaise: assert property (p_irqRaise) else $error("interrupt not raised");

            property p_noIrqMasked;
                @(posedge sys_clk) disable iff (!nrst) !irqEnable[i] |=> !irq_reg[i];
            endproperty
            a_noIrqMasked: assert property (p_noIrqMasked) else $error("masked interrupt raised");

            c_doneSet: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(done_reg[i]));
        end
    endgenerate

    property p_cfgWrite;
        @(posedge sys_clk) disable iff (!nrst)
            sfrWrEn && sfrAddr == acs_pkg::SLOW_CFG_ADDR |=> slowDiv_reg == $past(sfrWrData[7:3]);
    endproperty
    a_cfgWrite: assert property (p_cfgWrite) else $error("divider write lost");

    property p_lowBitsZero;
        @(posedge sys_clk) disable iff (!nrst) sfrRdData[2:0] == 3'h0;
    endproperty
    a_lowBitsZero: assert property (p_lowBitsZero) else $error("unused bits read nonzero");

    property p_timerSel;
        @(posedge sys_clk) disable iff (!nrst)
            mode[0] == acs_pkg::ACS_SRC_TIMER2 && !busy[0] && enable[0] && (t2Mode16 ? t2OvfHigh : t2OvfLow)
            |=> busy[0];
    endproperty
    a_timerSel: assert property (p_timerSel) else $error("timer overflow did not start");

    property p_diffFollow;
        @(posedge sys_clk) disable iff (!nrst) differentialSelect && busy[0] && busy[1] |-> trackHold[0] == trackHold[1];
    endproperty
    a_diffFollow: assert property (p_diffFollow) else $error("second converter not following");

    c_diffConv: cover property (@(posedge sys_clk) disable iff (!nrst) differentialSelect && $fell(busy[0]));
    c_extStart: cover property (@(posedge sys_clk) disable iff (!nrst) pinRise[0] && extMode[0]);

    assign sfrRdData        = rdData_reg;
    assign firstBusy        = busy[acs_pkg::CH_FIRST];
    assign firstDoneFlag    = done_reg[acs_pkg::CH_FIRST];
    assign firstIrq         = irq_reg[acs_pkg::CH_FIRST];
    assign firstTrackHold   = trackHold[acs_pkg::CH_FIRST];
    assign firstConvClk     = convClk[acs_pkg::CH_FIRST];
    assign firstResultHigh  = result[acs_pkg::CH_FIRST][15:8];
    assign firstResultLow   = result[acs_pkg::CH_FIRST][7:0];
    assign secondBusy       = busy[acs_pkg::CH_SECOND];
    assign secondDoneFlag   = done_reg[acs_pkg::CH_SECOND];
    assign secondIrq        = irq_reg[acs_pkg::CH_SECOND];
    assign secondTrackHold  = trackHold[acs_pkg::CH_SECOND];
    assign secondConvClk    = convClk[acs_pkg::CH_SECOND];
    assign secondResultHigh = result[acs_pkg::CH_SECOND][15:8];
    assign secondResultLow  = result[acs_pkg::CH_SECOND][7:0];
    assign slowBusy         = busy[acs_pkg::CH_SLOW];
    assign slowDoneFlag     = done_reg[acs_pkg::CH_SLOW];
    assign slowIrq          = irq_reg[acs_pkg::CH_SLOW];
    assign slowTrackHold    = trackHold[acs_pkg::CH_SLOW];
    assign slowConvClk      = convClk[acs_pkg::CH_SLOW];
    assign slowResultHigh   = result[acs_pkg::CH_SLOW][15:8];
    assign slowResultLow    = result[acs_pkg::CH_SLOW][7:0];
endmodule : acs_top

/* dv/acs_far.sv */
`timescale 1ns/1ps
module acs_far (
    input  wire logic        sys_clk,
    input  wire logic [1:0]  src,
    input  wire logic        go,
    input  wire logic [15:0] coreVal,
    output logic             t2OvfHigh,
    output logic             t3OvfHigh,
    output logic             extPin,
    output logic [15:0]      coreData
);
    always_ff @(posedge sys_clk) begin
        t3OvfHigh <= go && src == 2'h1;
        extPin    <= go && src == 2'h2;
        t2OvfHigh <= go && src == 2'h3;
        coreData  <= coreVal;
    end
endmodule : acs_far

/* dv/acs_top_tb_top.sv */
`timescale 1ns/1ps
module acs_top_tb_top;
    logic sys_clk = 0, nrst = 0, sfrWrEn = 0, t2OvfLow = 0, t3OvfLow = 0, t2Mode16 = 1, t3Mode16 = 1;
    logic [7:0] sfrAddr = 8'h00, sfrWrData = 8'h00, sfrRdData;
    logic t2OvfHigh, t3OvfHigh, firstExtStartPin, secondExtStartPin, slowExtStartPin = 0, go = 0;
    logic firstEnable = 1, firstTrackMode = 0, firstBusyWrite = 0, firstDoneClear = 0, firstIrqEnable = 1;
    logic secondEnable = 1, secondTrackMode = 0, secondBusyWrite = 0, secondDoneClear = 0, secondIrqEnable = 1;
    logic slowEnable = 1, slowTrackMode = 0, slowBusyWrite = 0, slowDoneClear = 0, slowIrqEnable = 1;
    logic differentialSelect = 0;
    logic [1:0] firstStartMode = 2'h0, slowStartMode = 2'h0;
    logic [2:0] secondStartMode = 3'h0;
    logic [3:0] firstClkDiv = 4'h0, secondClkDiv = 4'h0;
    logic [15:0] firstCoreData, secondCoreData = 16'h1234, diffCoreData = 16'hbeef, coreVal = 16'h0000;
    logic [9:0] slowCoreData = 10'h2a5;
    logic firstBusy, firstDoneFlag, firstIrq, firstTrackHold, firstConvClk;
    logic secondBusy, secondDoneFlag, secondIrq, secondTrackHold, secondConvClk;
    logic slowBusy, slowDoneFlag, slowIrq, slowTrackHold, slowConvClk;
    logic [7:0] firstResultHigh, firstResultLow, secondResultHigh, secondResultLow, slowResultHigh, slowResultLow;
    logic [17:0] rows [4] = '{18'h0a5a5, 18'h15a3c, 18'h2c3d4, 18'h3f00f};
    int failCount = 0, checksDone = 0, nBusy = 0;
    assign secondExtStartPin = firstExtStartPin;
    acs_top u_dut (.*);
    acs_far u_far (.sys_clk(sys_clk), .src(firstStartMode), .go(go), .coreVal(coreVal), .t2OvfHigh(t2OvfHigh),
                   .t3OvfHigh(t3OvfHigh), .extPin(firstExtStartPin), .coreData(firstCoreData));
    always #5 sys_clk = ~sys_clk;
    task tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : tick
    task automatic pulse(ref logic s);
        s = 1;
        tick(1);
        s = 0;
    endtask : pulse
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checksDone++;
        if (got !== exp) begin
            failCount++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task conv;
        int i;
        for (i = 0; i < 600 && !(firstBusy || slowBusy); i++) tick(1);
        for (i = 0; i < 600 && (firstBusy || slowBusy); i++) tick(1);
        if (i == 600) failCount++;
        tick(3);
    endtask : conv
    task report_and_stop;
        $display("checks %0d mismatches %0d", checksDone, failCount);
        if (failCount == 0 && checksDone > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    initial begin
        #100us;
        failCount++;
        report_and_stop;
    end
    initial begin
        tick(20);
        nrst = 1;
        sfrAddr = 8'hbc;
        tick(2);
        chk(sfrRdData, 16'h00f8);
        sfrWrData = 8'h4f;
        pulse(sfrWrEn);
        tick(1);
        chk(sfrRdData, 16'h0048);
        sfrAddr = 8'hbd;
        tick(2);
        chk(sfrRdData, 16'h0000);
        $display("register test done");
        for (int r = 0; r < 4; r++) begin
            firstStartMode = rows[r][17:16];
            coreVal = rows[r][15:0];
            pulse(firstDoneClear);
            chk(firstDoneFlag, 16'h0);
            if (r == 0) pulse(firstBusyWrite);
            else pulse(go);
            conv;
            chk({firstResultHigh, firstResultLow}, rows[r][15:0]);
            chk(firstDoneFlag, 16'h1);
            chk(firstIrq, 16'h1);
            chk(firstBusy, 16'h0);
            $display("row %0d done", r);
        end
        firstStartMode = 2'h1;
        pulse(firstDoneClear);
        pulse(t3OvfLow);
        tick(5);
        chk(firstBusy, 16'h0);
        t3Mode16 = 0;
        pulse(t3OvfLow);
        conv;
        chk(firstDoneFlag, 16'h1);
        $display("timer test done");
        firstStartMode = 2'h0;
        firstTrackMode = 1;
        pulse(firstBusyWrite);
        for (nBusy = 0; firstBusy && nBusy < 100; nBusy++) tick(1);
        chk(16'(nBusy), {11'h000, acs_pkg::TRACK_TICKS + acs_pkg::FAST_CONV_TICKS});
        tick(3);
        chk(firstTrackHold, 16'h1);
        firstTrackMode = 0;
        $display("track test done");
        secondStartMode = 3'h4;
        pulse(firstBusyWrite);
        conv;
        chk(secondDoneFlag, 16'h1);
        chk({secondResultHigh, secondResultLow}, secondCoreData);
        secondStartMode = 3'h0;
        $display("second converter test done");
        pulse(slowBusyWrite);
        conv;
        chk({slowResultHigh, slowResultLow}, {6'h00, slowCoreData});
        chk(slowDoneFlag, 16'h1);
        $display("slow test done");
        slowStartMode = 2'h2;
        pulse(slowDoneClear);
        chk(slowDoneFlag, 16'h0);
        pulse(slowExtStartPin);
        conv;
        chk(slowDoneFlag, 16'h1);
        slowStartMode = 2'h0;
        $display("slow pin test done");
        differentialSelect = 1;
        pulse(firstBusyWrite);
        conv;
        chk({firstResultHigh, firstResultLow}, diffCoreData);
        chk({secondResultHigh, secondResultLow}, secondCoreData);
        $display("differential test done");
        nrst = 0;
        tick(2);
        nrst = 1;
        tick(1);
        chk(firstDoneFlag, 16'h0);
        chk({firstResultHigh, firstResultLow}, 16'h0000);
        $display("reset test done");
        report_and_stop;
    end
endmodule : acs_top_tb_top
